// *** design/output_sync_dynamic_delay.sv ***
// Purpose: Holds selected divided output groups low on a sync event and
//          releases each after a fixed latency plus its digital delay.
// Assumes: pclk is the distribution-path clock; div_clk_in is synchronous.
// Notes:   Half-step is reported per group for the analog half-cycle shift.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sync_delay_defines.svh"

module output_sync_dynamic_delay
  import sync_delay_pkg::*;
#(
  parameter int NUM_GROUPS = 6,
  parameter int DLY_W      = 10
)(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic                    sync_pin,
  input  wire logic [NUM_GROUPS-1:0]   div_clk_in,
  output logic [2*NUM_GROUPS-1:0]      divided_clock_output,
  output logic [NUM_GROUPS-1:0]        group_half_step_out,
  output logic [NUM_GROUPS-1:0]        group_divider_restart,
  output logic                         sync_busy
);

  localparam int CW = DLY_W + 1;

  initial
  begin
    if (NUM_GROUPS < 2 || NUM_GROUPS > 8 || DLY_W < 4 || DLY_W > 16)
      $error("output_sync_dynamic_delay: unsupported parameters");
  end

  sync_ctrl_s                      ctrl;
  logic [NUM_GROUPS-1:0]           group_sync_exempt;
  logic [NUM_GROUPS-1:0]           group_half_step;
  logic [DLY_W-1:0]                group_digital_delay_count [NUM_GROUPS];
  logic [DLY_W-1:0]                active_delay [NUM_GROUPS];
  logic [NUM_GROUPS-1:0]           hold;
  logic                            pin_meta;
  logic                            pin_sync;
  logic [1:0]                      auto_cnt;
  logic                            raw_level;
  logic                            raw_prev;
  logic                            sync_level;
  logic                            sync_prev;
  logic                            assert_pulse;
  logic                            release_pulse;
  logic                            asrt_run;
  logic [3:0]                      asrt_cnt;
  logic                            hold_set;
  logic                            rel_run;
  logic [CW-1:0]                   rel_cnt;
  qual_state_e                     qstate;
  logic [1:0]                      qcnt;
  logic                            oneshot;
  logic                            qual_prev;
  logic                            qual_now;
  logic                            qual_fall;
  logic                            wr_en;
  logic                            rd_en;
  logic                            delay_hit;
  logic [2:0]                      delay_idx;
  logic                            addr_ok;
  logic [31:0]                     next_prdata;

  assign wr_en     = psel && penable && pready && pwrite;
  assign rd_en     = psel && !penable && !pwrite;
  assign delay_hit = paddr >= `ADDR_DELAY_BASE && paddr <= `ADDR_DELAY_LAST &&
                     paddr[1:0] == 2'h0;
  assign delay_idx = 3'((paddr - `ADDR_DELAY_BASE) >> 2);

  // Registered zero-wait answer: pready rises in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= rd_en ? next_prdata : 32'h0000_0000;
    end
  end

  always_comb
  begin
    addr_ok     = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr == `ADDR_CTRL)
    begin
      next_prdata[`CTRL_POL_BIT]                 = ctrl.polarity_invert;
      next_prdata[`CTRL_QUAL_BIT]                = ctrl.qualify_enable;
      next_prdata[`CTRL_AUTO_BIT]                = ctrl.auto_sync;
      next_prdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB]   = ctrl.qual_select;
      next_prdata[`CTRL_PD45_BIT]                = ctrl.four_five_powerdown;
    end
    else if (paddr == `ADDR_EXEMPT)
      next_prdata[NUM_GROUPS-1:0] = group_sync_exempt;
    else if (paddr == `ADDR_HALF_STEP)
      next_prdata[NUM_GROUPS-1:0] = group_half_step;
    else if (paddr == `ADDR_STATUS)
    begin
      next_prdata[`STAT_SYNC_BIT]  = sync_level;
      next_prdata[`STAT_HOLD_BIT]  = |hold;
      next_prdata[`STAT_REL_BIT]   = !group_sync_exempt[ctrl.qual_select];
      next_prdata[`STAT_QBUSY_BIT] = qstate != Q_IDLE;
      next_prdata[`STAT_MASK_LSB +: NUM_GROUPS] = hold;
    end
    else if (delay_hit && delay_idx < NUM_GROUPS)
      next_prdata[DLY_W-1:0] = group_digital_delay_count[delay_idx];
    else
      addr_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl              <= '0;
      group_sync_exempt <= {NUM_GROUPS{`RST_EXEMPT}};
      group_half_step   <= {NUM_GROUPS{`RST_HALF_STEP}};
    end
    else if (wr_en && paddr == `ADDR_CTRL)
    begin
      ctrl.polarity_invert     <= pwdata[`CTRL_POL_BIT];
      ctrl.qualify_enable      <= pwdata[`CTRL_QUAL_BIT];
      ctrl.auto_sync           <= pwdata[`CTRL_AUTO_BIT];
      ctrl.qual_select         <= pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      ctrl.four_five_powerdown <= pwdata[`CTRL_PD45_BIT];
    end
    else if (wr_en && paddr == `ADDR_EXEMPT)
      group_sync_exempt <= pwdata[NUM_GROUPS-1:0];
    else if (wr_en && paddr == `ADDR_HALF_STEP)
      group_half_step <= pwdata[NUM_GROUPS-1:0];
  end

  // Stored counts only reach the outputs via active_delay at a sync
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_GROUPS; i++)
        group_digital_delay_count[i] <= DLY_W'(`RST_DELAY);
    end
    else if (wr_en && delay_hit && delay_idx < NUM_GROUPS)
      group_digital_delay_count[delay_idx] <= pwdata[DLY_W-1:0];
  end

  // Auto-sync: a delay write asserts the internal request for a few cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      auto_cnt <= 2'h0;
    else if (wr_en && delay_hit && delay_idx < NUM_GROUPS && ctrl.auto_sync)
      auto_cnt <= 2'(`AUTO_WIDTH);
    else if (auto_cnt != 2'h0)
      auto_cnt <= auto_cnt - 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= sync_pin;
      pin_sync <= pin_meta;
    end
  end

  // Flipping the polarity bit itself is a valid way to request a sync
  assign raw_level = (pin_sync ^ ctrl.polarity_invert) || (auto_cnt != 2'h0);

  // Qualifier: the selected group's divided clock, sampled each cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qual_now  <= 1'b0;
      qual_prev <= 1'b0;
      raw_prev  <= 1'b0;
    end
    else
    begin
      // Out-of-range select reads low instead of unknown
      qual_now  <= (ctrl.qual_select < NUM_GROUPS) ? div_clk_in[ctrl.qual_select] : 1'b0;
      qual_prev <= qual_now;
      raw_prev  <= raw_level;
    end
  end

  assign qual_fall = qual_prev && !qual_now;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qstate  <= Q_IDLE;
      qcnt    <= 2'h0;
      oneshot <= 1'b0;
    end
    else
    begin
      unique case (qstate)
        Q_IDLE:
          if (ctrl.qualify_enable && raw_level && !raw_prev)
            qstate <= Q_WAIT;
        Q_WAIT:
          if (qual_fall)
          begin
            qstate <= Q_DELAY;
            qcnt   <= 2'(`QUAL_DELAY - 1);
          end
        Q_DELAY:
          if (qcnt == 2'h0)
          begin
            qstate  <= Q_PULSE;
            oneshot <= 1'b1;
            qcnt    <= 2'(`ONESHOT_WIDTH - 1);
          end
          else
            qcnt <= qcnt - 2'h1;
        Q_PULSE:
          if (qcnt == 2'h0)
          begin
            qstate  <= Q_IDLE;
            oneshot <= 1'b0;
          end
          else
            qcnt <= qcnt - 2'h1;
      endcase
    end
  end

  // One-shot replaces the raw level so no strict pin timing is needed
  assign sync_level    = ctrl.qualify_enable ? oneshot : raw_level;
  assign assert_pulse  = sync_level && !sync_prev;
  assign release_pulse = !sync_level && sync_prev;
  // Hold flop supplies the last cycle of the latency
  assign hold_set      = asrt_run && asrt_cnt == 4'(`SYNC_LATENCY - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_prev <= 1'b0;
      asrt_run  <= 1'b0;
      asrt_cnt  <= 4'h0;
    end
    else
    begin
      sync_prev <= sync_level;
      if (assert_pulse)
      begin
        asrt_run <= 1'b1;
        asrt_cnt <= 4'h1;
      end
      else if (hold_set)
        asrt_run <= 1'b0;
      else if (asrt_run)
        asrt_cnt <= asrt_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel_run <= 1'b0;
      rel_cnt <= '0;
    end
    else if (assert_pulse)
      rel_run <= 1'b0;
    else if (release_pulse)
    begin
      rel_run <= 1'b1;
      rel_cnt <= CW'(1);
    end
    else if (rel_run && rel_cnt != '1)
      rel_cnt <= rel_cnt + CW'(1);
    else
      rel_run <= 1'b0;
  end

  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : grp
    logic [CW-1:0] target;
    // One short: the hold flop adds the final edge
    assign target = CW'(`SYNC_LATENCY - 1) + {1'b0, active_delay[g]};

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        hold[g]                  <= 1'b0;
        active_delay[g]          <= DLY_W'(`RST_DELAY);
        group_divider_restart[g] <= 1'b0;
      end
      else
      begin
        group_divider_restart[g] <= 1'b0;
        // Qualifier group joins when not exempt: relative mode
        if (assert_pulse && !group_sync_exempt[g])
          active_delay[g] <= group_digital_delay_count[g];
        if (hold_set && !group_sync_exempt[g])
          hold[g] <= 1'b1;
        else if (hold[g] && (group_sync_exempt[g] || (rel_run && rel_cnt == target)))
        begin
          hold[g]                  <= 1'b0;
          group_divider_restart[g] <= !group_sync_exempt[g];
        end
      end
    end

    // Registered gate cannot clip a pulse shorter than a cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        divided_clock_output[2*g +: 2] <= 2'b00;
      else
        divided_clock_output[2*g +: 2] <= {2{div_clk_in[g] && !hold[g]}};
    end

    AST_HELD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      hold[g] |=> divided_clock_output[2*g +: 2] == 2'b00)
      else $error("held group output not low");
    AST_PAIR_SAME: assert property (@(posedge pclk) disable iff (!presetn)
      divided_clock_output[2*g] == divided_clock_output[2*g+1])
      else $error("group pair outputs differ");
    AST_EXEMPT_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      group_sync_exempt[g] && !hold[g] |=> divided_clock_output[2*g] == $past(div_clk_in[g]))
      else $error("exempt group output disturbed");
    AST_MIN_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      release_pulse && hold[g] && active_delay[g] == DLY_W'(`RST_DELAY) && !assert_pulse
      |=> hold[g] ##9 hold[g] ##1 !hold[g])
      else $error("release with delay 5 not at 11 cycles");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group_half_step_out <= {NUM_GROUPS{`RST_HALF_STEP}};
      sync_busy           <= 1'b0;
    end
    else
    begin
      group_half_step_out <= group_half_step;
      sync_busy           <= sync_level || asrt_run || (|hold);
    end
  end

  AST_ASSERT_LAT: assert property (@(posedge pclk) disable iff (!presetn)
    assert_pulse |=> !hold_set[*4] ##1 hold_set)
    else $error("hold not set six cycles after latch");
  AST_ONESHOT: assert property (@(posedge pclk) disable iff (!presetn)
    qstate == Q_WAIT && qual_fall |=> !oneshot[*3] ##1 oneshot[*3] ##1 !oneshot)
    else $error("one-shot timing wrong");
  AST_DELAY_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    !assert_pulse |=> active_delay[0] == $past(active_delay[0]))
    else $error("delay changed without sync");
  AST_HS_IMMEDIATE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `ADDR_HALF_STEP |=> ##1 group_half_step_out == $past(pwdata[NUM_GROUPS-1:0], 2))
    else $error("half-step not applied at once");
  AST_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && delay_hit && delay_idx < NUM_GROUPS && ctrl.auto_sync |=> raw_level[*3])
    else $error("auto-sync did not raise request");

endmodule : output_sync_dynamic_delay

// *** design/sync_delay_defines.svh ***
`ifndef SYNC_DELAY_DEFINES_SVH
`define SYNC_DELAY_DEFINES_SVH

// APB byte addresses
`define ADDR_CTRL       12'h000
`define ADDR_EXEMPT     12'h004
`define ADDR_HALF_STEP  12'h008
`define ADDR_STATUS     12'h00c
`define ADDR_DELAY_BASE 12'h010
`define ADDR_DELAY_LAST 12'h024

// Control register fields
`define CTRL_POL_BIT    0
`define CTRL_QUAL_BIT   1
`define CTRL_AUTO_BIT   2
`define CTRL_SEL_LSB    4
`define CTRL_SEL_MSB    6
`define CTRL_PD45_BIT   8

// Status register fields
`define STAT_SYNC_BIT   0
`define STAT_HOLD_BIT   1
`define STAT_REL_BIT    2
`define STAT_QBUSY_BIT  3
`define STAT_MASK_LSB   8

// Timing in distribution-path cycles
`define SYNC_LATENCY    6
`define QUAL_DELAY      3
`define ONESHOT_WIDTH   3
`define AUTO_WIDTH      3

// Reset values
`define RST_DELAY       5
`define RST_EXEMPT      1'b0
`define RST_HALF_STEP   1'b0
`define RST_SEL         3'h0

`endif

// *** design/sync_delay_pkg.sv ***
// Purpose: Types shared by the output sync and dynamic delay logic
// Assumes: Fields of the control word match the defines header
// Notes:   Packed so the whole word moves as one carrier
package sync_delay_pkg;

  typedef struct packed {
    logic       four_five_powerdown;
    logic [2:0] qual_select;
    logic       auto_sync;
    logic       qualify_enable;
    logic       polarity_invert;
  } sync_ctrl_s;

  typedef enum logic [3:0] {
    Q_IDLE  = 4'b0001,
    Q_WAIT  = 4'b0010,
    Q_DELAY = 4'b0100,
    Q_PULSE = 4'b1000
  } qual_state_e;

endpackage : sync_delay_pkg

// *** tb/divider_bank.sv ***
// Purpose: Model of the per-group output dividers that feed the sync block
// Assumes: Group g divides pclk by 2*(g+1); restart comes from the sync block
// Notes:   Parked high while not running, so held low outputs stand out
`timescale 1ns/1ps

module divider_bank #(
  parameter int NUM_GROUPS = 6
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  run,
  input  wire logic [NUM_GROUPS-1:0] restart,
  output logic      [NUM_GROUPS-1:0] div_clk
);
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : grp
    logic [3:0] count;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        count      <= 4'h0;
        div_clk[g] <= 1'b1;
      end
      else if (!run || restart[g])
      begin
        // Restart starts the phase on a rising level, as after a release
        count      <= 4'h0;
        div_clk[g] <= 1'b1;
      end
      else if (count == 4'(g))
      begin
        count      <= 4'h0;
        div_clk[g] <= ~div_clk[g];
      end
      else
      begin
        count <= count + 4'h1;
      end
    end
  end
endmodule : divider_bank

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the output sync and dynamic delay block
// Assumes: Divider model parked high except in the qualified tests
// Notes:   Edge counts are taken from the pin change to the output change
`timescale 1ns/1ps
`include "sync_delay_defines.svh"

module testbench;
  localparam int NG = 6;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic            sync_pin = 1'b0;
  logic            run = 1'b0;
  logic            pready, pslverr, busy;
  logic [31:0]     prdata, rd;
  logic            err;
  logic [NG-1:0]   div_clk, restart, hs_out, exempt, m;
  logic [2*NG-1:0] outs;
  int              err_total = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  int              t_low[NG] = '{default: -1};
  int              t_high[NG] = '{default: -1};
  int              dly[NG];
  int              n_restart[NG] = '{default: 0};

  output_sync_dynamic_delay #(.NUM_GROUPS(NG), .DLY_W(10)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sync_pin(sync_pin), .div_clk_in(div_clk), .divided_clock_output(outs),
    .group_half_step_out(hs_out), .group_divider_restart(restart), .sync_busy(busy));

  divider_bank #(.NUM_GROUPS(NG)) i_div (
    .pclk(pclk), .presetn(presetn), .run(run), .restart(restart), .div_clk(div_clk));

  always #12.5 pclk = ~pclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Setup then access; request held until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      summarize();
    end
  endtask : apb

  task arm;
    t_low = '{default: -1};
    t_high = '{default: -1};
    n_restart = '{default: 0};
  endtask : arm

  task wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 400)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      err_total++;
      summarize();
    end
  endtask : wait_busy

  task held_check(input int c0, input int r0, input logic exact);
    for (int g = 0; g < NG; g++)
      if (exempt[g])
        check(32'(t_low[g]), 32'hffffffff);
      else if (exact)
      begin
        check(32'(t_low[g] - c0), 32'd9);
        check(32'(t_high[g] - r0), 32'(9 + dly[g]));
      end
      else
        check({31'h0, t_low[g] >= 0 && t_high[g] > t_low[g]}, 32'h1);
  endtask : held_check

  // Both outputs of a group sampled every cycle; first low and high noted
  always @(posedge pclk)
  begin
    #1;
    cyc++;
    for (int g = 0; g < NG; g++)
    begin
      check(32'(outs[2*g]), 32'(outs[2*g+1]));
      if (restart[g] === 1'b1)
        n_restart[g]++;
      if (outs[2*g+:2] === 2'b00 && t_low[g] < 0)
        t_low[g] = cyc;
      if (outs[2*g+:2] === 2'b11 && t_low[g] >= 0 && t_high[g] < 0)
        t_high[g] = cyc;
    end
  end

  // Random delays and exempt mask; timing counted from pin edges
  task pin_round;
    int c0;
    int r0;
    for (int g = 0; g < NG; g++)
    begin
      dly[g] = $urandom_range(5, 12);
      apb(1'b1, 12'(`ADDR_DELAY_BASE + 4 * g), 32'(dly[g]));
    end
    exempt = 6'($urandom_range(0, 62));
    apb(1'b1, `ADDR_EXEMPT, 32'(exempt));
    apb(1'b0, `ADDR_EXEMPT, 32'h0);
    check(rd, 32'(exempt));
    arm();
    @(posedge pclk);
    sync_pin <= 1'b1;
    c0 = cyc + 1;
    repeat (14) @(posedge pclk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(rd, 32'({~exempt, 4'h0, 1'b0, ~exempt[0], 2'b11}));
    @(posedge pclk);
    sync_pin <= 1'b0;
    r0 = cyc + 1;
    repeat (25) @(posedge pclk);
    held_check(c0, r0, 1'b1);
    $display("done: pin sync round");
  endtask : pin_round

  initial
  begin
    void'($urandom(32'h82ceaf76));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `ADDR_HALF_STEP, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(rd, 32'h4);
    for (int g = 0; g < NG; g++)
    begin
      apb(1'b0, 12'(`ADDR_DELAY_BASE + 4 * g), 32'h0);
      check({rd[31:1], err}, 32'h4);
    end
    apb(1'b1, 12'h028, 32'hffffffff);
    apb(1'b0, 12'h028, 32'h0);
    check({rd[31:1], err}, 32'h1);
    $display("done: reset values");
    repeat (2) pin_round();
    m = 6'($urandom_range(0, 63));
    apb(1'b1, `ADDR_HALF_STEP, 32'(m));
    repeat (2) @(posedge pclk);
    #1;
    check(32'(hs_out), 32'(m));
    check(32'(busy), 32'h0);
    $display("done: half step");
    for (int k = 0; k < 2; k++)
    begin
      arm();
      if (k == 0)
      begin
        apb(1'b1, `ADDR_CTRL, 32'h101);
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check(rd, 32'h101);
        repeat (20) @(posedge pclk);
      end
      else
      begin
        dly[0] = 5;
        apb(1'b1, `ADDR_CTRL, 32'h4);
        apb(1'b1, `ADDR_DELAY_BASE, 32'h5);
      end
      apb(1'b1, `ADDR_CTRL, 32'h0);
      repeat (40) @(posedge pclk);
      held_check(0, 0, 1'b0);
      $display("done: polarity or auto sync %0d", k);
    end
    run <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      m = 6'($urandom_range(0, 5));
      exempt = (k == 0) ? 6'(1 << m) : 6'h0;
      apb(1'b1, `ADDR_EXEMPT, 32'(exempt));
      // Group four-five stays powered while qualifying
      apb(1'b1, `ADDR_CTRL, 32'({m[2:0], 4'h2}));
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check(32'(rd[2]), 32'(k));
      arm();
      @(posedge pclk);
      sync_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      sync_pin <= 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      check(32'(n_restart[m]), 32'(k));
      $display("done: qualified sync %0d", k);
    end
    summarize();
  end
endmodule : testbench
